/* File: core/ise_pkg.sv */
// constants, state encodings and the state record of the i2c serial engine
// assumes a 40 mhz aclk and an axi4-lite master with 18-bit byte addresses
package ise_pkg;

    localparam int ADDR_W = 18;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_OSA = 16'hffa6;
    localparam logic [15:0] IDX_CTL0 = 16'hffa8;
    localparam logic [15:0] IDX_CTL1 = 16'hffa9;
    localparam logic [15:0] IDX_DATA = 16'hffaa;
    localparam logic [15:0] IDX_STAT = 16'hffab;
    localparam logic [15:0] IDX_IEN = 16'hffac;
    localparam logic [15:0] IDX_ICLR = 16'hffad;
    localparam logic [15:0] IDX_IST = 16'hffae;

    // control 0 fields
    localparam int C0_EN = 7;
    localparam int C0_REL = 5;
    localparam int C0_SPIE = 4;
    localparam int C0_WTIM = 3;
    localparam int C0_ACK = 2;
    localparam int C0_STT = 1;
    localparam int C0_SPT = 0;
    // control 1 fields
    localparam int C1_WAKE = 0;
    localparam int C1_RSV = 1;
    // interrupt status bits
    localparam int IS_XFER = 0;
    localparam int IS_STOP = 1;
    localparam int IS_WAKE = 2;
    localparam int IS_SFAIL = 3;

    localparam logic [6:0] OSA_RST = 7'h00;
    localparam logic [4:0] EXT_CODE = 5'h1e;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    localparam int CLK_NS = 25;
    localparam int SCL_HALF_NS = 5000;
    localparam int HOLD_NS = 25;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;

    // gray along idle, setup, start, low, high, stop1, stop2
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_SETUP = 3'h1,
        M_START = 3'h3,
        M_LOW = 3'h2,
        M_HIGH = 3'h6,
        M_STOP1 = 3'h7,
        M_STOP2 = 3'h5
    } ise_mst_t;

    typedef struct packed {
        logic awv; logic [ADDR_W-1:0] awa; logic wv; logic [7:0] wd; logic ws;
        logic bv; logic [1:0] br; logic rv; logic [7:0] rd; logic [1:0] rr;
        logic [6:0] osa; logic en; logic spie; logic wtim; logic ack_en;
        logic wake_en; logic rsv_dis; logic [3:0] ien; logic [3:0] ist;
        logic [7:0] txb; logic [7:0] rxb;
        logic scl_m; logic scl_s; logic scl_p; logic sda_m; logic sda_s; logic sda_p;
        logic busy; logic master; logic adr; logic first; logic dir_rd; logic tx;
        logic ack_rcv; logic stfail; logic arb_lost; logic ext; logic st_pend;
        logic [3:0] cnt; logic [7:0] rsh; logic [3:0] hold; logic hold_on;
        logic sda_pend; logic sda_l; logic wait_h; ise_mst_t ms; logic [7:0] tcnt;
    } ise_state_t;

endpackage

/* File: core/ise_top.sv */
// i2c serial engine: master/slave byte engine, wake on address match, axi4-lite regs
// assumes open-drain wiring outside (oe high pulls low) and pull-ups on both lines
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps

module ise_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic stop_mode,
    input wire logic [ise_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ise_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_line_i,
    output logic serial_clock_line_o,
    output logic serial_clock_line_oe,
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe,
    output logic bus_irq
);

    ise_pkg::ise_state_t r;
    ise_pkg::ise_state_t n;
    logic fall, rise, sta, sto, half;
    logic do_wr, start_req, stop_req, rel, inv, ntx, mt, ex;
    logic [3:0] k;
    logic [8:0] rdv;

    function automatic logic hit(input logic [ise_pkg::ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // {known, data}; clear register is write-only and reads zero
    function automatic logic [8:0] rreg(input logic [ise_pkg::ADDR_W-1:0] a,
                                        input ise_pkg::ise_state_t s);
        logic [8:0] v;
        v = 9'h000;
        if (hit(a, ise_pkg::IDX_OSA))
            v = {1'b1, s.osa, 1'b0};
        else if (hit(a, ise_pkg::IDX_CTL0))
            v = {1'b1, s.en, 2'b00, s.spie, s.wtim, s.ack_en, 2'b00};
        else if (hit(a, ise_pkg::IDX_CTL1))
            v = {1'b1, 6'h00, s.rsv_dis, s.wake_en};
        else if (hit(a, ise_pkg::IDX_DATA))
            v = {1'b1, s.rxb};
        else if (hit(a, ise_pkg::IDX_STAT))
            v = {1'b1, s.sda_l, s.ext, s.adr, s.master,
                 s.arb_lost, s.ack_rcv, s.stfail, s.busy};
        else if (hit(a, ise_pkg::IDX_IEN))
            v = {1'b1, 4'h0, s.ien};
        else if (hit(a, ise_pkg::IDX_ICLR))
            v = {1'b1, 8'h00};
        else if (hit(a, ise_pkg::IDX_IST))
            v = {1'b1, 4'h0, s.ist};
        return v;
    endfunction

    // edges seen on the second synchroniser stage only
    assign fall = r.scl_p & ~r.scl_s;
    assign rise = ~r.scl_p & r.scl_s;
    assign sta = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    assign sto = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
    assign half = r.tcnt == 8'(ise_pkg::SCL_HALF_CYC - 1);

    always_comb
    begin
        n = r;
        do_wr = r.awv & r.wv & ~r.bv;
        start_req = 1'b0;
        stop_req = 1'b0;
        rel = 1'b0;
        inv = 1'b0;
        ntx = r.tx;
        mt = 1'b0;
        ex = 1'b0;
        k = 4'h0;
        rdv = rreg(s_axi_araddr, r);
        n.scl_m = serial_clock_line_i;
        n.scl_s = r.scl_m;
        n.scl_p = r.scl_s;
        n.sda_m = serial_data_line_i;
        n.sda_s = r.sda_m;
        n.sda_p = r.sda_s;

        // axi write: address and data held independently, applied together
        if (s_axi_awvalid && !r.awv)
        begin
            n.awv = 1'b1;
            n.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.wv)
        begin
            n.wv = 1'b1;
            n.wd = s_axi_wdata[7:0];
            n.ws = s_axi_wstrb[0];
        end
        if (r.bv && s_axi_bready)
            n.bv = 1'b0;
        if (do_wr)
        begin
            n.awv = 1'b0;
            n.wv = 1'b0;
            n.bv = 1'b1;
            n.br = rreg(r.awa, r) != 9'h000 ? ise_pkg::RESP_OK : ise_pkg::RESP_ERR;
            if (r.ws)
            begin
                if (hit(r.awa, ise_pkg::IDX_OSA))
                    n.osa = r.wd[7:1];
                if (hit(r.awa, ise_pkg::IDX_CTL0))
                begin
                    n.en = r.wd[ise_pkg::C0_EN];
                    n.spie = r.wd[ise_pkg::C0_SPIE];
                    n.wtim = r.wd[ise_pkg::C0_WTIM];
                    n.ack_en = r.wd[ise_pkg::C0_ACK];
                    rel = r.wd[ise_pkg::C0_REL];
                    start_req = r.wd[ise_pkg::C0_STT] & r.wd[ise_pkg::C0_EN];
                    stop_req = r.wd[ise_pkg::C0_SPT] & r.wd[ise_pkg::C0_EN];
                end
                if (hit(r.awa, ise_pkg::IDX_CTL1))
                begin
                    n.wake_en = r.wd[ise_pkg::C1_WAKE];
                    n.rsv_dis = r.wd[ise_pkg::C1_RSV];
                end
                if (hit(r.awa, ise_pkg::IDX_DATA))
                begin
                    n.txb = r.wd;
                    rel = 1'b1;
                end
                if (hit(r.awa, ise_pkg::IDX_IEN))
                    n.ien = r.wd[3:0];
                if (hit(r.awa, ise_pkg::IDX_ICLR))
                    n.ist = r.ist & ~r.wd[3:0];
            end
        end

        // axi read
        if (r.rv && s_axi_rready)
            n.rv = 1'b0;
        if (s_axi_arvalid && !r.rv)
        begin
            n.rv = 1'b1;
            n.rd = rdv[7:0];
            n.rr = rdv[8] ? ise_pkg::RESP_OK : ise_pkg::RESP_ERR;
        end

        if (rel || stop_req)
            n.wait_h = 1'b0;
        if (start_req)
        begin
            n.stfail = 1'b0;
            n.arb_lost = 1'b0;
        end

        // hold correction: pending level lands after the hold delay
        if (r.hold_on)
        begin
            if (r.hold == 4'h0)
            begin
                n.sda_l = r.sda_pend;
                n.hold_on = 1'b0;
            end
            else
                n.hold = r.hold - 4'h1;
        end

        if (r.en)
        begin
            if (sta)
            begin
                n.busy = 1'b1;
                n.cnt = 4'h0;
                n.first = 1'b1;
                n.adr = 1'b0;
                n.ext = 1'b0;
                n.tx = r.master;
            end
            if (sto)
            begin
                n.busy = 1'b0;
                n.cnt = 4'h0;
                n.adr = 1'b0;
                n.wait_h = 1'b0;
                if (r.spie)
                    n.ist[ise_pkg::IS_STOP] = 1'b1;
            end
            if (rise && !sta && !sto)
            begin
                if (r.cnt < 4'h8)
                begin
                    n.rsh = {r.rsh[6:0], r.sda_s};
                    // released a one but read a zero: another master won
                    if (r.master && r.tx && r.sda_l && !r.sda_s)
                    begin
                        n.master = 1'b0;
                        n.arb_lost = 1'b1;
                        n.ms = ise_pkg::M_IDLE;
                    end
                end
                if (r.cnt == 4'h8)
                    n.ack_rcv = ~r.sda_s;
                n.cnt = r.cnt + 4'h1;
            end
            if (fall)
            begin
                inv = r.master | r.adr;
                if (r.cnt == 4'h8)
                begin
                    n.rxb = r.rsh;
                    if (r.first && !r.master)
                    begin
                        mt = r.rsh[7:1] == r.osa;
                        ex = r.rsh[7:3] == ise_pkg::EXT_CODE;
                        n.adr = mt;
                        n.ext = ex;
                        n.dir_rd = r.rsh[0];
                        inv = mt;
                        if (stop_mode && r.wake_en && (mt || ex))
                            n.ist[ise_pkg::IS_WAKE] = 1'b1;
                    end
                    else if (r.first)
                        n.dir_rd = r.txb[0];
                end
                if (r.cnt == 4'h9)
                begin
                    n.cnt = 4'h0;
                    n.first = 1'b0;
                    if (r.first)
                        ntx = r.master ? ~r.dir_rd : r.dir_rd;
                    n.tx = ntx;
                end
                k = r.cnt == 4'h9 ? 4'h0 : r.cnt;
                n.hold_on = 1'b1;
                n.hold = 4'(ise_pkg::HOLD_CYC - 1);
                if (k < 4'h8)
                    n.sda_pend = !(ntx && inv) || r.txb[3'd7 - k[2:0]];
                else
                    n.sda_pend = !(!ntx && inv && r.ack_en);
                if (inv && ((r.cnt == 4'h8 && !r.wtim) || (r.cnt == 4'h9 && r.wtim)))
                begin
                    n.wait_h = 1'b1;
                    n.ist[ise_pkg::IS_XFER] = 1'b1;
                end
            end

            if (start_req)
            begin
                if (!r.master && r.busy && r.rsv_dis)
                begin
                    n.stfail = 1'b1;
                    n.ist[ise_pkg::IS_SFAIL] = 1'b1;
                end
                else if (!r.master && r.busy)
                    n.st_pend = 1'b1;
                else
                begin
                    n.master = 1'b1;
                    n.ms = ise_pkg::M_SETUP;
                    n.tcnt = 8'h00;
                    n.wait_h = 1'b0;
                end
            end
            // reserved start fires once the bus is released
            if (r.st_pend && !r.busy && r.ms == ise_pkg::M_IDLE)
            begin
                n.st_pend = 1'b0;
                n.master = 1'b1;
                n.ms = ise_pkg::M_SETUP;
                n.tcnt = 8'h00;
            end

            case (r.ms)
                ise_pkg::M_IDLE:
                    n.tcnt = 8'h00;
                ise_pkg::M_SETUP:
                begin
                    n.sda_l = 1'b1;
                    n.hold_on = 1'b0;
                    if (r.scl_s)
                        n.tcnt = r.tcnt + 8'h01;
                    if (half)
                    begin
                        n.ms = ise_pkg::M_START;
                        n.tcnt = 8'h00;
                    end
                end
                ise_pkg::M_START:
                begin
                    n.sda_l = 1'b0;
                    n.tcnt = r.tcnt + 8'h01;
                    if (half)
                    begin
                        n.ms = ise_pkg::M_LOW;
                        n.tcnt = 8'h00;
                    end
                end
                ise_pkg::M_LOW:
                begin
                    if (!half)
                        n.tcnt = r.tcnt + 8'h01;
                    if (stop_req)
                    begin
                        n.ms = ise_pkg::M_STOP1;
                        n.tcnt = 8'h00;
                    end
                    else if (half && !r.wait_h)
                    begin
                        n.ms = ise_pkg::M_HIGH;
                        n.tcnt = 8'h00;
                    end
                end
                ise_pkg::M_HIGH:
                begin
                    // slave stretching holds the line low; count only once high
                    if (r.scl_s)
                        n.tcnt = r.tcnt + 8'h01;
                    if (half)
                    begin
                        n.ms = ise_pkg::M_LOW;
                        n.tcnt = 8'h00;
                    end
                end
                ise_pkg::M_STOP1:
                begin
                    n.sda_l = 1'b0;
                    n.hold_on = 1'b0;
                    n.tcnt = r.tcnt + 8'h01;
                    if (half)
                    begin
                        n.ms = ise_pkg::M_STOP2;
                        n.tcnt = 8'h00;
                    end
                end
                ise_pkg::M_STOP2:
                begin
                    if (r.scl_s)
                        n.tcnt = r.tcnt + 8'h01;
                    if (half)
                    begin
                        n.sda_l = 1'b1;
                        n.master = 1'b0;
                        n.ms = ise_pkg::M_IDLE;
                    end
                end
                default:
                    n.ms = ise_pkg::M_IDLE;
            endcase
        end
        else
        begin
            n.ms = ise_pkg::M_IDLE;
            n.master = 1'b0;
            n.sda_l = 1'b1;
            n.hold_on = 1'b0;
            n.wait_h = 1'b0;
            n.st_pend = 1'b0;
            n.busy = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '{osa: ise_pkg::OSA_RST, scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, sda_l: 1'b1,
                   ms: ise_pkg::M_IDLE, default: '0};
        else if (ce)
            r <= n;
    end

    assign s_axi_awready = ~r.awv;
    assign s_axi_wready = ~r.wv;
    assign s_axi_bvalid = r.bv;
    assign s_axi_bresp = r.br;
    assign s_axi_arready = ~r.rv;
    assign s_axi_rvalid = r.rv;
    assign s_axi_rdata = {24'h000000, r.rd};
    assign s_axi_rresp = r.rr;
    // open drain: output value fixed low, enable pulls the line
    assign serial_clock_line_o = 1'b0;
    assign serial_data_line_o = 1'b0;
    assign serial_clock_line_oe = (r.ms == ise_pkg::M_LOW) || (r.ms == ise_pkg::M_STOP1)
                                  || r.wait_h;
    assign serial_data_line_oe = ~r.sda_l;
    assign bus_irq = |(r.ist & r.ien);

    a_wake_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r.ist[ise_pkg::IS_WAKE]) |-> $past(stop_mode) && $past(r.wake_en))
        else $error("wake flag set outside stop mode");
    a_wake_match: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && r.en && fall && r.cnt == 4'h8 && r.first && !r.master && stop_mode
         && r.wake_en && r.rsh[7:1] == r.osa) |=> r.ist[ise_pkg::IS_WAKE])
        else $error("own address match missed wake flag");
    a_osa_lsb: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, ise_pkg::IDX_OSA) && ce)
        |=> s_axi_rvalid && s_axi_rdata[0] == 1'b0 && s_axi_rdata[7:1] == $past(r.osa))
        else $error("own address readback wrong");
    a_xfer_point: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r.ist[ise_pkg::IS_XFER]) |-> $past(fall)
        && $past(r.cnt) == ($past(r.wtim) ? 4'h9 : 4'h8))
        else $error("transfer flag at wrong clock");
    a_stop_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && r.en && sto && r.spie) |=> r.ist[ise_pkg::IS_STOP] && !r.busy)
        else $error("stop detect did not flag");
    a_scl_master: assert property (@(posedge aclk) disable iff (!aresetn)
        (serial_clock_line_oe && !r.wait_h) |-> r.master)
        else $error("clock driven while not master");
    a_cnt_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && r.en && rise && !sta && !sto) |=> r.cnt == $past(r.cnt) + 4'h1)
        else $error("clock counter did not step");
    a_start_fail: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && r.en && start_req && !r.master && r.busy && r.rsv_dis)
        |=> r.stfail && r.ms == ise_pkg::M_IDLE && !r.master)
        else $error("start on busy bus not refused");
    a_start_seq: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && r.en && r.ms == ise_pkg::M_START && half) |=> r.ms == ise_pkg::M_LOW && !r.sda_l)
        else $error("start condition not completed");
    a_stop_seq: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && r.en && r.ms == ise_pkg::M_STOP2 && half) |=> r.sda_l && r.ms == ise_pkg::M_IDLE)
        else $error("stop condition not completed");
    a_hold_first: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && r.en && fall && !r.hold_on && r.ms != ise_pkg::M_SETUP && r.ms != ise_pkg::M_START
         && r.ms != ise_pkg::M_STOP1 && r.ms != ise_pkg::M_STOP2 && !start_req && !stop_req)
        |=> r.sda_l == $past(r.sda_l))
        else $error("data moved without hold delay");

endmodule

/* File: tb/ise_far_end.sv */
// far side of the i2c link: pull-ups, a master that sends bytes, a slave that acks
// assumes the engine's oe outputs pull low; timing is behavioural, 200 ns link clock
`timescale 1ns/1ps
module ise_far_end (
    input wire logic dut_scl_oe,
    input wire logic dut_sda_oe,
    output logic scl,
    output logic sda
);
    logic m_scl_low = 1'b0;
    logic m_sda_low = 1'b0;
    logic ack_low = 1'b0;
    logic ack_mode = 1'b0;
    logic stop_seen = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    int rises = 0;
    // released lines read high through the pull-ups
    assign scl = !(dut_scl_oe || m_scl_low);
    assign sda = !(dut_sda_oe || m_sda_low || ack_low);
    always @(posedge scl)
    begin
        rx_byte = {rx_byte[6:0], sda};
        rises++;
    end
    always @(negedge sda)
        if (scl)
        begin
            rises = 0;
            stop_seen = 1'b0;
        end
    always @(posedge sda)
        if (scl)
            stop_seen = 1'b1;
    // ack held from eighth to ninth fall, after a hold delay
    always @(negedge scl)
        ack_low <= #50 ack_mode && rises == 8;
    task automatic send_start();
        m_sda_low = 1'b1;
        #2500 m_scl_low = 1'b1;
    endtask
    task automatic bit_out(input logic b);
        #20 m_sda_low = !b;
        #80 m_scl_low = 1'b0;
        // the engine may stretch the low phase
        wait (scl);
        #100 m_scl_low = 1'b1;
    endtask
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            bit_out(v[i]);
        bit_out(1'b1);
    endtask
    task automatic send_stop();
        #20 m_sda_low = 1'b1;
        #80 m_scl_low = 1'b0;
        #100 m_sda_low = 1'b0;
    endtask
endmodule

/* File: tb/tb.sv */
// testbench of the i2c serial engine: axi4-lite register tasks, master and slave traffic
// assumes the far-end model for the bus lines; ce stays high
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic stop_mode = 1'b0;
    logic [17:0] awaddr = 18'h0;
    logic [17:0] araddr = 18'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, scl, sda, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata;
    logic [7:0] d;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    always #12.5 aclk = ~aclk;
    ise_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .stop_mode(stop_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_clock_line_i(scl), .serial_clock_line_o(), .serial_clock_line_oe(scl_oe),
        .serial_data_line_i(sda), .serial_data_line_o(), .serial_data_line_oe(sda_oe),
        .bus_irq(irq));
    ise_far_end i_far (.dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .scl(scl), .sda(sda));
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx, output logic [7:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        v = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] m, input logic [7:0] e);
        rd(idx, d, r);
        `CHK(d & m, e)
    endtask
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(ise_pkg::IDX_OSA, 8'hff, 8'h00);
        `CHK(r, ise_pkg::RESP_OK)
        wr(ise_pkg::IDX_OSA, 8'hff);
        `CHK(bresp, ise_pkg::RESP_OK)
        rdc(ise_pkg::IDX_OSA, 8'hff, 8'hfe);
        rd(16'h0001, d, r);
        `CHK(r, ise_pkg::RESP_ERR)
        // master: address byte 0xa0, wait at ninth fall, then stop
        i_far.ack_mode = 1'b1;
        wr(ise_pkg::IDX_IEN, 8'h03);
        wr(ise_pkg::IDX_DATA, 8'ha0);
        // enable ahead of the start: a start in the enabling write itself is dropped
        wr(ise_pkg::IDX_CTL0, 8'h98);
        wr(ise_pkg::IDX_CTL0, 8'h9a);
        wait (irq);
        `CHK(i_far.rises, 9)
        `CHK(i_far.rx_byte, 8'h40)
        repeat (50) @(posedge aclk);
        `CHK(scl, 1'b0)
        rdc(ise_pkg::IDX_IST, 8'hff, 8'h01);
        rdc(ise_pkg::IDX_STAT, 8'h15, 8'h15);
        wr(ise_pkg::IDX_ICLR, 8'h01);
        wr(ise_pkg::IDX_CTL0, 8'h99);
        wait (irq);
        rdc(ise_pkg::IDX_IST, 8'hff, 8'h02);
        `CHK(i_far.stop_seen, 1'b1)
        // slave: wake on own address in stop mode, then a start refused while busy
        i_far.ack_mode = 1'b0;
        wr(ise_pkg::IDX_ICLR, 8'h0f);
        wr(ise_pkg::IDX_OSA, 8'h42);
        wr(ise_pkg::IDX_CTL1, 8'h03);
        wr(ise_pkg::IDX_CTL0, 8'h84);
        wr(ise_pkg::IDX_IEN, 8'h0c);
        stop_mode <= 1'b1;
        fork
            begin
                i_far.send_start();
                i_far.send_byte(8'h42);
            end
            begin
                wait (irq);
                rdc(ise_pkg::IDX_IST, 8'h04, 8'h04);
                wr(ise_pkg::IDX_CTL0, 8'ha4);
            end
        join
        `CHK(i_far.rx_byte[0], 1'b0)
        stop_mode <= 1'b0;
        wr(ise_pkg::IDX_ICLR, 8'h0f);
        wr(ise_pkg::IDX_CTL0, 8'h86);
        rdc(ise_pkg::IDX_STAT, 8'h03, 8'h03);
        rdc(ise_pkg::IDX_IST, 8'h08, 8'h08);
        i_far.send_stop();
        repeat (10) @(posedge aclk);
        rdc(ise_pkg::IDX_STAT, 8'h01, 8'h00);
        conclude();
    end
endmodule
